// ---- hdl/stt_consts.svh ----
// constants of the system tick timer: offsets, fields, reset values
`ifndef STT_CONSTS_SVH
`define STT_CONSTS_SVH
`define STT_OFS_CTRL      12'h010
`define STT_OFS_RESTART   12'h014
`define STT_OFS_COUNT     12'h018
`define STT_OFS_CALIB     12'h01C
`define STT_OFS_IRQ_STAT  12'h020
`define STT_OFS_IRQ_MASK  12'h024
`define STT_BIT_ENABLE    0
`define STT_BIT_EXC_EN    1
`define STT_BIT_SOURCE    2
`define STT_BIT_ZERO      16
`define STT_BIT_MISSING   31
`define STT_BIT_INEXACT   30
`define STT_CAL_COUNT     24'hC35
`define STT_CAL_MISSING   1'h0
`define STT_CAL_INEXACT   1'h1
`define STT_REF_DIVIDE    6'h20
`define STT_RESET_CTRL    1'h0
`endif

// ---- hdl/stt_pkg.sv ----
// types of the system tick timer
package stt_pkg;
   typedef logic [23:0] stt_count_t;
   typedef enum logic [1:0] {
      STT_IDLE,
      STT_LOAD,
      STT_RUN
   } stt_state_t;
endpackage

// ---- hdl/stt_ref_tick.sv ----
// reference tick generator: oscillator divided by 32, edges to sys_clk pulses
`include "stt_consts.svh"
module stt_ref_tick (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic oscClk,
   output logic      refTick
);
   logic [5:0] divCnt_q;
   logic       divOut_q;
   logic       sync1_q;
   logic       sync2_q;
   logic       sync3_q;

   // oscillator is treated as an ordinary pin, sampled in sys_clk domain
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
      end else begin
         sync1_q <= oscClk;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   // count oscillator rising edges; one tick per 32 of them
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         divCnt_q <= 6'h00;
         divOut_q <= 1'b0;
      end else begin
         divOut_q <= 1'b0;
         if (sync2_q && !sync3_q) begin
            if (divCnt_q == `STT_REF_DIVIDE - 6'h01) begin
               divCnt_q <= 6'h00;
               divOut_q <= 1'b1;
            end else begin
               divCnt_q <= divCnt_q + 6'h01;
            end
         end
      end
   end

   assign refTick = divOut_q;
endmodule

// ---- hdl/stt_timer.sv ----
// system tick timer: 24-bit down counter with register port and interrupt
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`include "stt_consts.svh"
module stt_timer (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        oscClk,
   input  wire logic [11:0] regAddr,
   input  wire logic [31:0] regWrData,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   output logic [31:0]      regRdData,
   output logic             tickPend,
   output logic             irq
);
   logic                  refTick;
   logic                  tick;
   logic                  enable_q;
   logic                  tick_exception_enable_q;
   logic                  source_q;
   logic                  zeroFlag_q;
   stt_pkg::stt_count_t   restart_q;
   stt_pkg::stt_count_t   count_q;
   stt_pkg::stt_state_t   state_q;
   logic                  zeroHit;
   logic                  tickPend_q;
   logic [1:0]            irqStat_q;
   logic [1:0]            irqMask_q;
   logic [31:0]           rdData_q;
   logic                  wrCtrl;
   logic                  wrRestart;
   logic                  wrCount;
   logic                  rdCtrl;
   logic                  rdStat;

   stt_ref_tick u_ref (
      .sys_clk (sys_clk),
      .rst     (rst),
      .oscClk  (oscClk),
      .refTick (refTick)
   );

   // address decode
   assign wrCtrl    = regWrite && regAddr == `STT_OFS_CTRL;
   assign wrRestart = regWrite && regAddr == `STT_OFS_RESTART;
   assign wrCount   = regWrite && regAddr == `STT_OFS_COUNT;
   assign rdCtrl    = regRead && regAddr == `STT_OFS_CTRL;
   assign rdStat    = regRead && regAddr == `STT_OFS_IRQ_STAT;

   // counting clock choice
   assign tick = source_q ? 1'b1 : refTick;

   // control bits; only the three defined bits are stored
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         enable_q  <= `STT_RESET_CTRL;
         tick_exception_enable_q <= `STT_RESET_CTRL;
         source_q  <= `STT_RESET_CTRL;
      end else if (wrCtrl) begin
         enable_q  <= regWrData[`STT_BIT_ENABLE];
         tick_exception_enable_q <= regWrData[`STT_BIT_EXC_EN];
         source_q  <= regWrData[`STT_BIT_SOURCE];
      end
   end

   // restart value, upper byte dropped
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         restart_q <= 24'h000000;
      end else if (wrRestart) begin
         restart_q <= regWrData[23:0];
      end
   end

   // run state: enabling forces a load before counting starts
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q <= stt_pkg::STT_IDLE;
      end else begin
         case (state_q)
            stt_pkg::STT_IDLE: begin
               if (wrCtrl && regWrData[`STT_BIT_ENABLE]) begin
                  state_q <= stt_pkg::STT_LOAD;
               end
            end
            stt_pkg::STT_LOAD: begin
               state_q <= enable_q ? stt_pkg::STT_RUN : stt_pkg::STT_IDLE;
            end
            stt_pkg::STT_RUN: begin
               if (!enable_q) begin
                  state_q <= stt_pkg::STT_IDLE;
               end
            end
            default: begin
               state_q <= stt_pkg::STT_IDLE;
            end
         endcase
      end
   end

   // a tick on zero reloads rather than wraps; only the step from 1 to 0 counts as reached
   assign zeroHit = state_q == stt_pkg::STT_RUN && tick
                    && count_q == 24'h000001;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         count_q <= 24'h000000;
      end else if (wrCount) begin
         count_q <= 24'h000000;
      end else if (state_q == stt_pkg::STT_LOAD) begin
         count_q <= restart_q;
      end else if (state_q == stt_pkg::STT_RUN && tick) begin
         if (count_q == 24'h000000) begin
            count_q <= restart_q;
         end else begin
            count_q <= count_q - 24'h000001;
         end
      end
   end

   // zero flag: a set in the cycle of a clearing read still wins
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         zeroFlag_q <= 1'b0;
      end else if (zeroHit) begin
         zeroFlag_q <= 1'b1;
      end else if (rdCtrl || wrCount) begin
         zeroFlag_q <= 1'b0;
      end
   end

   // tick exception pend pulse, one cycle per zero
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tickPend_q <= 1'b0;
      end else begin
         tickPend_q <= zeroHit && tick_exception_enable_q;
      end
   end
   assign tickPend = tickPend_q;

   // sticky event status: bit0 zero reached, bit1 tick pended
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irqStat_q <= 2'h0;
      end else begin
         irqStat_q <= (rdStat ? 2'h0 : irqStat_q)
                      | {zeroHit && tick_exception_enable_q, zeroHit};
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irqMask_q <= 2'h0;
      end else if (regWrite && regAddr == `STT_OFS_IRQ_MASK) begin
         irqMask_q <= regWrData[1:0];
      end
   end

   assign irq = |(irqStat_q & irqMask_q);

   // read data, one cycle after the strobe, zero when idle or unmapped
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdData_q <= 32'h00000000;
      end else begin
         rdData_q <= 32'h00000000;
         if (regRead) begin
            case (regAddr)
               `STT_OFS_CTRL: begin
                  rdData_q[`STT_BIT_ZERO]    <= zeroFlag_q;
                  rdData_q[`STT_BIT_SOURCE]  <= source_q;
                  rdData_q[`STT_BIT_EXC_EN]  <= tick_exception_enable_q;
                  rdData_q[`STT_BIT_ENABLE]  <= enable_q;
               end
               `STT_OFS_RESTART: begin
                  rdData_q[23:0] <= restart_q;
               end
               `STT_OFS_COUNT: begin
                  rdData_q[23:0] <= count_q;
               end
               `STT_OFS_CALIB: begin
                  rdData_q[`STT_BIT_MISSING] <= `STT_CAL_MISSING;
                  rdData_q[`STT_BIT_INEXACT] <= `STT_CAL_INEXACT;
                  rdData_q[23:0]             <= `STT_CAL_COUNT;
               end
               `STT_OFS_IRQ_STAT: begin
                  rdData_q[1:0] <= irqStat_q;
               end
               `STT_OFS_IRQ_MASK: begin
                  rdData_q[1:0] <= irqMask_q;
               end
               default: begin
                  rdData_q <= 32'h00000000;
               end
            endcase
         end
      end
   end
   assign regRdData = rdData_q;
endmodule

// ---- test/stt_timer_chk.sv ----
// port checker of the tick timer
`include "stt_consts.svh"
module stt_timer_chk (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic [11:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic        regWrite,
   input wire logic        regRead,
   input wire logic [31:0] regRdData,
   input wire logic        tickPend
);
   logic exEn_q;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst)
         exEn_q <= 1'b0;
      else if (regWrite && regAddr == `STT_OFS_CTRL)
         exEn_q <= regWrData[1];
   end
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   sequence rdAt(a);
      regRead && regAddr == a;
   endsequence
   // a zero hit between write and read would set the flag again
   sequence clrRd;
      regWrite && regAddr == `STT_OFS_COUNT ##2 rdAt(`STT_OFS_CTRL);
   endsequence
   chk_idle_zero: assert property (!regRead |=> regRdData == 32'h0)
      else $error("read data not zero");
   chk_calib_value: assert property (rdAt(`STT_OFS_CALIB) |=>
      regRdData == 32'h40000C35) else $error("calibration word");
   chk_restart_top: assert property (rdAt(`STT_OFS_RESTART) |=>
      regRdData[31:24] == 8'h00) else $error("restart top byte");
   chk_count_top: assert property (rdAt(`STT_OFS_COUNT) |=>
      regRdData[31:24] == 8'h00) else $error("count top byte");
   chk_ctrl_unused: assert property (rdAt(`STT_OFS_CTRL) |=>
      (regRdData & 32'hFFFEFFF8) == 32'h0) else $error("control unused");
   chk_unmapped_zero: assert property (regRead &&
      (regAddr < 12'h010 || regAddr > 12'h024) |=> regRdData == 32'h0)
      else $error("unmapped read");
   chk_clear_flag: assert property (clrRd |=> !regRdData[16])
      else $error("flag kept after clear");
   chk_pend_pulse: assert property (tickPend |=> !tickPend)
      else $error("pend too long");
   chk_pend_enable: assert property (tickPend |->
      exEn_q || $past(exEn_q)) else $error("pend while off");
endmodule

bind stt_timer stt_timer_chk chk_u (
   .sys_clk(sys_clk),
   .rst(rst),
   .regAddr(regAddr),
   .regWrData(regWrData),
   .regWrite(regWrite),
   .regRead(regRead),
   .regRdData(regRdData),
   .tickPend(tickPend)
);

// ---- test/system_tick_timer_tb.sv ----
// self-checking bench of the system tick timer
`include "stt_consts.svh"
module system_tick_timer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        oscClk = 1'b0;
   logic [2:0]  oscDiv = 3'h0;
   logic [11:0] regAddr = 12'h000;
   logic [31:0] regWrData = 32'h0;
   logic        regWrite = 1'b0;
   logic        regRead = 1'b0;
   logic [31:0] regRdData;
   logic        tickPend;
   logic        irq;
   logic [31:0] rdv;
   logic [31:0] v1;
   int          fails = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   int          pends = 0;
   int          n;
   stt_timer dut_u (
      .sys_clk(sys_clk),
      .rst(rst),
      .oscClk(oscClk),
      .regAddr(regAddr),
      .regWrData(regWrData),
      .regWrite(regWrite),
      .regRead(regRead),
      .regRdData(regRdData),
      .tickPend(tickPend),
      .irq(irq)
   );
   always #2 sys_clk = ~sys_clk;
   // oscillator of ten core cycles, so a reference tick is 320 cycles
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      oscDiv <= (oscDiv == 3'h4) ? 3'h0 : oscDiv + 3'h1;
      if (oscDiv == 3'h4)
         oscClk <= ~oscClk;
      if (tickPend === 1'b1)
         pends <= pends + 1;
      if (cyc == 5000) begin
         fails = fails + 1;
         summarize();
      end
   end
   task automatic eq(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge sys_clk);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge sys_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge sys_clk);
      regRead <= 1'b0;
      #1;
      rdv = regRdData;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      rd(a);
      eq(rdv, e);
   endtask
   // cycles between two exception pulses
   task automatic gap(output int k);
      k = 0;
      do begin
         @(posedge sys_clk);
         #1;
      end while (tickPend !== 1'b1);
      do begin
         @(posedge sys_clk);
         #1;
         k++;
      end while (tickPend !== 1'b1);
   endtask
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      rdc(`STT_OFS_CTRL, 32'h0);
      rdc(`STT_OFS_CALIB, 32'h40000C35);
      wr(`STT_OFS_CALIB, 32'hFFFFFFFF);
      rdc(`STT_OFS_CALIB, 32'h40000C35);
      rdc(12'h030, 32'h0);
      wr(`STT_OFS_RESTART, 32'hFFFFFFFF);
      rdc(`STT_OFS_RESTART, 32'h00FFFFFF);
      wr(`STT_OFS_CTRL, 32'h5);
      repeat (10) @(posedge sys_clk);
      rd(`STT_OFS_COUNT);
      v1 = rdv;
      rd(`STT_OFS_COUNT);
      eq(v1 - rdv, 32'h2);
      wr(`STT_OFS_RESTART, 32'h3);
      // a running timer reloads only on a fresh enable or on a tick at zero
      wr(`STT_OFS_CTRL, 32'h0);
      wr(`STT_OFS_CTRL, 32'h7);
      gap(n);
      eq(32'(n), 32'h4);
      wr(`STT_OFS_CTRL, 32'h0);
      rdc(`STT_OFS_CTRL, 32'h00010000);
      rdc(`STT_OFS_CTRL, 32'h0);
      eq({31'h0, irq}, 32'h0);
      wr(`STT_OFS_IRQ_MASK, 32'h1);
      #1;
      eq({31'h0, irq}, 32'h1);
      rdc(`STT_OFS_IRQ_STAT, 32'h3);
      eq({31'h0, irq}, 32'h0);
      wr(`STT_OFS_CTRL, 32'h5);
      n = pends;
      repeat (30) @(posedge sys_clk);
      eq(32'(pends - n), 32'h0);
      wr(`STT_OFS_CTRL, 32'h0);
      wr(`STT_OFS_COUNT, 32'hABCDEF);
      rdc(`STT_OFS_CTRL, 32'h0);
      rdc(`STT_OFS_COUNT, 32'h0);
      wr(`STT_OFS_RESTART, 32'h1);
      wr(`STT_OFS_CTRL, 32'h3);
      gap(n);
      eq(32'(n), 32'h280);
      summarize();
   end
endmodule
